/* File: rtl/dual_host_arb_map.vh */
// Functional notes
// - Reset: port zero owns control, both alerts asserted, status byte 0x45.
// - clear_faults is accepted from either port, owner or not.
// - A clear drops only the issuer's alert; start-up clears give 0x05 then 0x01.
// - Port one command while port zero owns: reject, alert one, byte 0xC1.
// - Port zero command while port one owns: reject, alert zero, 0x10 to 0x1C.
// - Port one takeover: both alerts asserted, status byte 0x74.
// - Then clear by one leaves 0x14; later clear by zero leaves 0x10.
// - Port zero takeover: both alerts asserted, status byte 0x47.
// - Then clear by zero leaves 0x41; later clear by one leaves 0x01.
// - Reading status alters nothing; hosts learn lost control by reading.
// - A supply fault latches into the fault word and asserts both alerts.
// - Only the owner's clear empties latched fault status; others leave it.
// - After recovery non-owner clear drops its alert; owner clear zeroes word.
// - While a fault is present the non-owner's alert is not released.
// - Supply alarms never change the arbitration status byte.
// - Owner port one bad command: alert one, byte 0xD0, word 0x0002, cml 0x80.
`ifndef DUAL_HOST_ARB_MAP_VH
`define DUAL_HOST_ARB_MAP_VH

`define BUS_W            8
`define WORD_W           16
`define CML_W            8

`define BUS_RESET        8'h45
`define WORD_RESET       16'h0000
`define CML_RESET        8'h00

// arbitration byte layout, port zero low nibble, port one high nibble
`define B_CTRL0          0
`define B_TOOK0          1
`define B_PEND0          2
`define B_REJ0           3
`define B_CTRL1          4
`define B_TOOK1          5
`define B_PEND1          6
`define B_REJ1           7

`define WORD_CML_BIT     1
`define CML_BADCMD_BIT   7

`endif

/* File: rtl/dual_host_arbiter.v */
`timescale 1ns/1ps
`include "dual_host_arb_map.vh"

module dual_host_arbiter #(
    parameter WORD_W = `WORD_W
) (
    input  wire              clk_sys,
    input  wire              resetn,
    // port zero request strobes, one cycle each, from its protocol engine
    input  wire              p0_clear_faults,
    input  wire              p0_command,
    input  wire              p0_bad_command,
    input  wire              p0_take_control,
    // port one request strobes
    input  wire              p1_clear_faults,
    input  wire              p1_command,
    input  wire              p1_bad_command,
    input  wire              p1_take_control,
    // asynchronous fault sources of the supply, level per bit
    input  wire [WORD_W-1:0] supply_fault,
    // status visible to both hosts
    output reg  [7:0]        status_bus_ff,
    output reg  [WORD_W-1:0] status_word_ff,
    output reg  [7:0]        status_cml_ff,
    output reg               owner_is_one_ff,
    // open-drain alert pins, enable high pulls the line low
    output reg               alert0_out_ff,
    output reg               alert0_oe_ff,
    output reg               alert1_out_ff,
    output reg               alert1_oe_ff
);

    ////////////////////////////////////////////////////////////////////////
    // fault capture

    wire [WORD_W-1:0] fault_lvl;
    reg  [WORD_W-1:0] fault_prev_ff;
    wire              fault_present;
    wire              fault_rise;

    pin_sync3 #(
        .W        (WORD_W)
    ) u_fault_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .pin_in   (supply_fault),
        .level_ff (fault_lvl)
    );

    assign fault_present = |fault_lvl;
    // new fault only; a standing fault must not re-raise cleared alerts
    assign fault_rise    = |(fault_lvl & ~fault_prev_ff);

    ////////////////////////////////////////////////////////////////////////
    // request classification

    wire p0_clr;
    wire p0_own_clr;
    wire p0_rej;
    wire p0_err;
    wire p0_take;
    wire p1_clr;
    wire p1_own_clr;
    wire p1_rej;
    wire p1_err;
    wire p1_take;

    host_port_gate u_gate0 (
        .clr_req  (p0_clear_faults),
        .cmd_req  (p0_command),
        .bad_req  (p0_bad_command),
        .take_req (p0_take_control),
        .in_ctrl  (~owner_is_one_ff),
        .do_clr   (p0_clr),
        .own_clr  (p0_own_clr),
        .rej      (p0_rej),
        .err      (p0_err),
        .take     (p0_take)
    );

    host_port_gate u_gate1 (
        .clr_req  (p1_clear_faults),
        .cmd_req  (p1_command),
        .bad_req  (p1_bad_command),
        .take_req (p1_take_control),
        .in_ctrl  (owner_is_one_ff),
        .do_clr   (p1_clr),
        .own_clr  (p1_own_clr),
        .rej      (p1_rej),
        .err      (p1_err),
        .take     (p1_take)
    );

    ////////////////////////////////////////////////////////////////////////
    // arbitration byte and ownership

    reg [7:0] nxt_status_bus;
    reg       nxt_owner_is_one;

    // nothing here looks at the fault inputs, so alarms leave the byte alone
    always @* begin
        nxt_status_bus   = status_bus_ff;
        nxt_owner_is_one = owner_is_one_ff;
        // clears first so a same-cycle event still lands
        if (p0_clr) begin
            nxt_status_bus[`B_PEND0] = 1'b0;
            nxt_status_bus[`B_TOOK0] = 1'b0;
            nxt_status_bus[`B_REJ0]  = 1'b0;
        end
        if (p1_clr) begin
            nxt_status_bus[`B_PEND1] = 1'b0;
            nxt_status_bus[`B_TOOK1] = 1'b0;
            nxt_status_bus[`B_REJ1]  = 1'b0;
        end
        if (p1_take) begin
            nxt_owner_is_one         = 1'b1;
            nxt_status_bus[`B_CTRL0] = 1'b0;
            nxt_status_bus[`B_TOOK0] = 1'b0;
            nxt_status_bus[`B_CTRL1] = 1'b1;
            nxt_status_bus[`B_TOOK1] = 1'b1;
            nxt_status_bus[`B_PEND0] = 1'b1;
            nxt_status_bus[`B_PEND1] = 1'b1;
        end
        if (p0_take) begin
            nxt_owner_is_one         = 1'b0;
            nxt_status_bus[`B_CTRL1] = 1'b0;
            nxt_status_bus[`B_TOOK1] = 1'b0;
            nxt_status_bus[`B_CTRL0] = 1'b1;
            nxt_status_bus[`B_TOOK0] = 1'b1;
            nxt_status_bus[`B_PEND0] = 1'b1;
            nxt_status_bus[`B_PEND1] = 1'b1;
        end
        if (p0_rej | p0_err) begin
            nxt_status_bus[`B_REJ0]  = 1'b1;
            nxt_status_bus[`B_PEND0] = 1'b1;
        end
        if (p1_rej | p1_err) begin
            nxt_status_bus[`B_REJ1]  = 1'b1;
            nxt_status_bus[`B_PEND1] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched fault word and communication error byte

    reg [WORD_W-1:0] nxt_status_word;
    reg [7:0]        nxt_status_cml;

    always @* begin
        nxt_status_word = status_word_ff;
        nxt_status_cml  = status_cml_ff;
        // a clear from the non-owner leaves the latch untouched
        if (p0_own_clr | p1_own_clr) begin
            nxt_status_word = {WORD_W{1'b0}};
            nxt_status_cml  = 8'h00;
        end
        // still-present fault re-latches over the clear
        nxt_status_word = nxt_status_word | fault_lvl;
        if (p0_err | p1_err) begin
            nxt_status_word[`WORD_CML_BIT]  = 1'b1;
            nxt_status_cml[`CML_BADCMD_BIT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alert lines

    reg nxt_alert0;
    reg nxt_alert1;

    always @* begin
        nxt_alert0 = alert0_oe_ff;
        nxt_alert1 = alert1_oe_ff;
        // each clear touches only its own line; the non-owner holds on
        // while the fault is still there so it cannot miss the event
        if (p0_clr && !(fault_present && owner_is_one_ff)) begin
            nxt_alert0 = 1'b0;
        end
        if (p1_clr && !(fault_present && !owner_is_one_ff)) begin
            nxt_alert1 = 1'b0;
        end
        if (fault_rise | p0_take | p1_take) begin
            nxt_alert0 = 1'b1;
            nxt_alert1 = 1'b1;
        end
        if (p0_rej | p0_err) begin
            nxt_alert0 = 1'b1;
        end
        if (p1_rej | p1_err) begin
            nxt_alert1 = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers; no read path exists, so reads change nothing

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_bus_ff   <= `BUS_RESET;
            status_word_ff  <= `WORD_RESET;
            status_cml_ff   <= `CML_RESET;
            owner_is_one_ff <= 1'b0;
            alert0_oe_ff    <= 1'b1;
            alert1_oe_ff    <= 1'b1;
            alert0_out_ff   <= 1'b0;
            alert1_out_ff   <= 1'b0;
            fault_prev_ff   <= {WORD_W{1'b0}};
        end else begin
            status_bus_ff   <= nxt_status_bus;
            status_word_ff  <= nxt_status_word;
            status_cml_ff   <= nxt_status_cml;
            owner_is_one_ff <= nxt_owner_is_one;
            alert0_oe_ff    <= nxt_alert0;
            alert1_oe_ff    <= nxt_alert1;
            // open drain: data stays low, only the enable moves
            alert0_out_ff   <= 1'b0;
            alert1_out_ff   <= 1'b0;
            fault_prev_ff   <= fault_lvl;
        end
    end

endmodule // dual_host_arbiter

/* File: rtl/host_port_gate.v */
`timescale 1ns/1ps
// classifies one port's request pulses against current ownership
module host_port_gate (
    input  wire clr_req,
    input  wire cmd_req,
    input  wire bad_req,
    input  wire take_req,
    input  wire in_ctrl,
    output wire do_clr,
    output wire own_clr,
    output wire rej,
    output wire err,
    output wire take
);
    assign do_clr  = clr_req;
    assign own_clr = clr_req & in_ctrl;
    assign rej     = (cmd_req | bad_req) & ~in_ctrl;
    assign err     = bad_req & in_ctrl;
    assign take    = take_req & ~in_ctrl;
endmodule // host_port_gate

/* File: rtl/pin_sync3.v */
`timescale 1ns/1ps
// three-stage capture; value moves on only when stages two and three agree
module pin_sync3 #(
    parameter W = 16
) (
    input  wire         clk_sys,
    input  wire         resetn,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] level_ff
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s1_ff    <= {W{1'b0}};
            s2_ff    <= {W{1'b0}};
            s3_ff    <= {W{1'b0}};
            level_ff <= {W{1'b0}};
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // per-bit agreement filters a single metastable sample
            level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff ^ s3_ff));
        end
    end
endmodule // pin_sync3

/* File: tb/dual_host_arbiter_chk.sv */
`timescale 1ns/1ps
module dual_host_arbiter_chk #(
    parameter WORD_W = 16
) (
    input wire              clk_sys,
    input wire              resetn,
    input wire              p0_clear_faults,
    input wire              p0_command,
    input wire              p0_bad_command,
    input wire              p0_take_control,
    input wire              p1_clear_faults,
    input wire              p1_command,
    input wire              p1_bad_command,
    input wire              p1_take_control,
    input wire [WORD_W-1:0] supply_fault,
    input wire [7:0]        status_bus_ff,
    input wire [WORD_W-1:0] status_word_ff,
    input wire [7:0]        status_cml_ff,
    input wire              owner_is_one_ff,
    input wire              alert0_out_ff,
    input wire              alert0_oe_ff,
    input wire              alert1_out_ff,
    input wire              alert1_oe_ff
);
    wire quiet = ~|{p0_command, p0_bad_command, p0_take_control,
                    p1_command, p1_bad_command, p1_take_control};
    wire idle  = quiet & ~p0_clear_faults & ~p1_clear_faults;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_reset_load: assert property ($rose(resetn) |-> status_bus_ff == 8'h45
        && alert0_oe_ff && alert1_oe_ff) else $error("reset state wrong");
    a_clear_one: assert property (p1_clear_faults && quiet |=>
        status_bus_ff[7:5] == 3'b000) else $error("port one clear wrong");
    a_clear_zero: assert property (p0_clear_faults && quiet |=>
        status_bus_ff[3:1] == 3'b000) else $error("port zero clear wrong");
    a_reject_one: assert property (p1_command && !owner_is_one_ff |=>
        status_bus_ff[7] && alert1_oe_ff) else $error("port one reject wrong");
    a_reject_zero: assert property (p0_command && owner_is_one_ff |=>
        status_bus_ff[3] && alert0_oe_ff) else $error("port zero reject wrong");
    a_take_one: assert property (p1_take_control && !owner_is_one_ff && !p0_take_control
        |=> owner_is_one_ff && status_bus_ff[5:4] == 2'b11 && status_bus_ff[1:0] == 2'b00
        && alert0_oe_ff && alert1_oe_ff) else $error("port one takeover wrong");
    a_take_zero: assert property (p0_take_control && owner_is_one_ff && !p1_take_control
        |=> !owner_is_one_ff && status_bus_ff[1:0] == 2'b11 && status_bus_ff[5:4] == 2'b00
        && alert0_oe_ff && alert1_oe_ff) else $error("port zero takeover wrong");
    a_bus_still: assert property (idle |=> $stable(status_bus_ff))
        else $error("status byte moved without request");
    a_bad_owner: assert property (p1_bad_command && owner_is_one_ff |=> status_word_ff[1]
        && status_cml_ff[7] && alert1_oe_ff) else $error("owner bad command wrong");
    a_word_kept: assert property (p1_clear_faults && !owner_is_one_ff && !p0_clear_faults
        |=> (status_word_ff & $past(status_word_ff)) == $past(status_word_ff))
        else $error("non-owner clear emptied fault word");
    // pin must be high two samples to pass the filter, word lands five edges after
    a_fault_latch: assert property ($rose(|supply_fault) ##1 (|supply_fault) |-> ##4
        (|status_word_ff && alert0_oe_ff && alert1_oe_ff)) else $error("fault not latched");
    a_alert_data_low: assert property (!alert0_out_ff && !alert1_out_ff)
        else $error("open-drain alert data not low");
    c_take: cover property (p1_take_control && !owner_is_one_ff);
    c_reject: cover property (p0_command && owner_is_one_ff);
    c_bad: cover property (p1_bad_command && owner_is_one_ff);
    c_fault: cover property ($rose(|status_word_ff));
endmodule // dual_host_arbiter_chk
bind dual_host_arbiter dual_host_arbiter_chk #(.WORD_W(WORD_W)) chk_u (
    .clk_sys(clk_sys), .resetn(resetn), .p0_clear_faults(p0_clear_faults),
    .p0_command(p0_command), .p0_bad_command(p0_bad_command),
    .p0_take_control(p0_take_control), .p1_clear_faults(p1_clear_faults),
    .p1_command(p1_command), .p1_bad_command(p1_bad_command),
    .p1_take_control(p1_take_control), .supply_fault(supply_fault),
    .status_bus_ff(status_bus_ff), .status_word_ff(status_word_ff),
    .status_cml_ff(status_cml_ff), .owner_is_one_ff(owner_is_one_ff),
    .alert0_out_ff(alert0_out_ff), .alert0_oe_ff(alert0_oe_ff),
    .alert1_out_ff(alert1_out_ff), .alert1_oe_ff(alert1_oe_ff));

/* File: tb/dual_host_arbiter_tb.sv */
`timescale 1ns/1ps
module dual_host_arbiter_tb;
    reg         clk_sys = 1'b0;
    reg         resetn = 1'b0;
    reg         op_go = 1'b0;
    reg         op_port = 1'b0;
    reg  [1:0]  op_kind = 2'b00;
    reg  [15:0] supply_fault = 16'h0000;
    wire [3:0]  p0_req;
    wire [3:0]  p1_req;
    wire [7:0]  bus;
    wire [15:0] word;
    wire [7:0]  cml;
    wire        a0_oe, a1_oe, a0_pin, a1_pin;
    integer     bad_count = 0;
    integer     checks_done = 0;
    always #20 clk_sys = ~clk_sys;
    host_pair_model host_u (.clk_sys(clk_sys), .op_go(op_go), .op_port(op_port),
        .op_kind(op_kind), .alert0_oe(a0_oe), .alert1_oe(a1_oe), .p0_req(p0_req),
        .p1_req(p1_req), .alert0_pin(a0_pin), .alert1_pin(a1_pin));
    dual_host_arbiter #(.WORD_W(16)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
        .p0_clear_faults(p0_req[0]), .p0_command(p0_req[1]), .p0_bad_command(p0_req[2]),
        .p0_take_control(p0_req[3]), .p1_clear_faults(p1_req[0]), .p1_command(p1_req[1]),
        .p1_bad_command(p1_req[2]), .p1_take_control(p1_req[3]),
        .supply_fault(supply_fault), .status_bus_ff(bus), .status_word_ff(word),
        .status_cml_ff(cml), .owner_is_one_ff(), .alert0_out_ff(), .alert0_oe_ff(a0_oe),
        .alert1_out_ff(), .alert1_oe_ff(a1_oe));
    ////////////////////////////////////////////////////////////////////////
    task final_report;
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // alert columns are asserted flags, pins read low when asserted
    task chk(input [7:0] eb, input e1, input e0, input [15:0] ew, input [7:0] ec);
        reg [33:0] exp;
        exp = {~e1, ~e0, eb, ew, ec};
        checks_done = checks_done + 1;
        if ({a1_pin, a0_pin, bus, word, cml} !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time,
                {a1_pin, a0_pin, bus, word, cml}, exp);
        end
    endtask
    task op(input p, input [1:0] k);
        @(posedge clk_sys);
        op_go <= 1'b1;
        op_port <= p;
        op_kind <= k;
        @(posedge clk_sys);
        op_go <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task fault(input [15:0] f);
        @(posedge clk_sys);
        supply_fault <= f;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        bad_count = bad_count + 1;
        final_report;
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        #1 chk(8'h45, 1, 1, 16'h0000, 8'h00);
        op(1, 0); chk(8'h05, 0, 1, 16'h0000, 8'h00);
        op(0, 0); chk(8'h01, 0, 0, 16'h0000, 8'h00);
        op(1, 1); chk(8'hC1, 1, 0, 16'h0000, 8'h00);
        op(1, 0); chk(8'h01, 0, 0, 16'h0000, 8'h00);
        fault(16'h0004); chk(8'h01, 1, 1, 16'h0004, 8'h00);
        op(1, 0); chk(8'h01, 1, 1, 16'h0004, 8'h00);
        op(0, 0); chk(8'h01, 1, 0, 16'h0004, 8'h00);
        fault(16'h0000); chk(8'h01, 1, 0, 16'h0004, 8'h00);
        op(1, 0); chk(8'h01, 0, 0, 16'h0004, 8'h00);
        op(0, 0); chk(8'h01, 0, 0, 16'h0000, 8'h00);
        op(1, 3); chk(8'h74, 1, 1, 16'h0000, 8'h00);
        op(1, 0); chk(8'h14, 0, 1, 16'h0000, 8'h00);
        op(0, 0); chk(8'h10, 0, 0, 16'h0000, 8'h00);
        op(0, 1); chk(8'h1C, 0, 1, 16'h0000, 8'h00);
        op(0, 0); chk(8'h10, 0, 0, 16'h0000, 8'h00);
        op(1, 2); chk(8'hD0, 1, 0, 16'h0002, 8'h80);
        op(1, 0); chk(8'h10, 0, 0, 16'h0000, 8'h00);
        op(0, 3); chk(8'h47, 1, 1, 16'h0000, 8'h00);
        op(0, 0); chk(8'h41, 1, 0, 16'h0000, 8'h00);
        op(1, 0); chk(8'h01, 0, 0, 16'h0000, 8'h00);
        op(0, 2); chk(8'h0D, 0, 1, 16'h0002, 8'h80);
        op(0, 0); chk(8'h01, 0, 0, 16'h0000, 8'h00);
        op(1, 2); chk(8'hC1, 1, 0, 16'h0000, 8'h00);
        op(1, 0); chk(8'h01, 0, 0, 16'h0000, 8'h00);
        op(0, 3); chk(8'h01, 0, 0, 16'h0000, 8'h00);
        repeat (5) @(posedge clk_sys);
        #1 chk(8'h01, 0, 0, 16'h0000, 8'h00);
        op(1, 1); chk(8'hC1, 1, 0, 16'h0000, 8'h00);
        // mid-run reset must wipe the reject just made
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        #1 chk(8'h45, 1, 1, 16'h0000, 8'h00);
        op(1, 0); chk(8'h05, 0, 1, 16'h0000, 8'h00);
        final_report;
    end
endmodule // dual_host_arbiter_tb

/* File: tb/host_pair_model.sv */
`timescale 1ns/1ps
// two hosts: one-cycle request strobes, alert pins resolved with pull-ups
module host_pair_model (
    input  wire       clk_sys,
    input  wire       op_go,
    input  wire       op_port,
    input  wire [1:0] op_kind,
    input  wire       alert0_oe,
    input  wire       alert1_oe,
    output reg  [3:0] p0_req,
    output reg  [3:0] p1_req,
    output wire       alert0_pin,
    output wire       alert1_pin
);
    initial begin
        p0_req = 4'h0;
        p1_req = 4'h0;
    end
    // kind 0 clear, 1 command, 2 bad command, 3 take control
    always @(posedge clk_sys) begin
        p0_req <= (op_go && !op_port) ? 4'h1 << op_kind : 4'h0;
        p1_req <= (op_go && op_port) ? 4'h1 << op_kind : 4'h0;
    end
    // released line floats to the pull-up level
    assign alert0_pin = alert0_oe ? 1'b0 : 1'b1;
    assign alert1_pin = alert1_oe ? 1'b0 : 1'b1;
endmodule // host_pair_model
